// *** src/asrc_ctrl.v ***
// How it works
// [R1] sixteen-bit word address selects one word
// [R2] chip select low needed; high means standby
// [R3] output gate high keeps memory pins floating
// [R4] two lane selects qualify upper, lower byte
// [R5] upper select pins 8-15, lower 0-7
// [R6] select, gate low, strobe high: memory reads
// [R7] select, strobe low: lanes written, gate ignored
// [R8] write window is select and strobe overlap
// [R9] hold write data past the ending edge
// [R10] keep output gate high during writes
// [R11] never drive pins while memory drives
// [R12] address valid before chip select falls
// [R13] unselected byte stays unchanged on write
// [R14] memory is clockless, contents undefined initially
`timescale 1ns/1ps
`include "asrc_regs.vh"

// =====================================================================
// controller for a 64k x 16 asynchronous static memory
// =====================================================================
module asrc_ctrl #(
	parameter AW = `ASRC_ADDR_W,
	parameter DW = `ASRC_DATA_W
) (
	input  wire          clock_i,
	input  wire          arst_n_i,
	input  wire          ce_i,
	// user side
	input  wire          req_i,
	input  wire          we_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	input  wire [1:0]    be_i,
	output wire          ready_o,
	output wire          rvalid_o,
	output wire [DW-1:0] rdata_o,
	output wire          wdone_o,
	// memory pins
	output wire [AW-1:0] word_addr_o,
	output wire          chip_sel_n_o,
	output wire          out_gate_n_o,
	output wire          write_strobe_n_o,
	output wire          upper_lane_sel_n_o,
	output wire          lower_lane_sel_n_o,
	input  wire [DW-1:0] data_pins_i,
	output wire [DW-1:0] data_pins_o,
	output wire [DW-1:0] data_pins_oe_o
);

	localparam HW = DW / 2;
	localparam CW = `ASRC_CNT_W;

	localparam [2:0] S_IDLE   = 3'h0;
	localparam [2:0] S_SETUP  = 3'h1;
	localparam [2:0] S_RD_ACC = 3'h2;
	localparam [2:0] S_RD_END = 3'h3;
	localparam [2:0] S_WR_PLS = 3'h4;
	localparam [2:0] S_WR_END = 3'h5;
	localparam [2:0] S_TURN   = 3'h6;

	localparam integer  ACC_CYC = `ASRC_ACC_CYC;
	localparam integer  WP_CYC  = `ASRC_WP_CYC;
	localparam integer  HZ_CYC  = `ASRC_HZ_CYC;
	localparam [CW-1:0] ACC_LD  = ACC_CYC[CW-1:0] - 1'b1;
	localparam [CW-1:0] WP_LD   = WP_CYC[CW-1:0] - 1'b1;
	localparam [CW-1:0] HZ_LD   = HZ_CYC[CW-1:0] - 1'b1;

	// =================================================================
	// state and output registers
	// =================================================================
	reg [2:0]    state_reg;
	reg [2:0]    state_next;
	reg [CW-1:0] cnt_reg;
	reg [CW-1:0] cnt_next;
	reg          wr_reg;
	reg [AW-1:0] addr_reg;
	reg          cs_n_reg;
	reg          cs_n_next;
	reg          og_n_reg;
	reg          og_n_next;
	reg          we_n_reg;
	reg          we_n_next;
	reg          ready_reg;
	reg          ready_next;
	reg          rvalid_reg;
	reg          rvalid_next;
	reg          wdone_reg;
	reg          wdone_next;
	reg          sel_on_next;
	reg          drive_next;
	reg          load;
	reg          capture;

	// =================================================================
	// next-state logic
	// =================================================================
	always @* begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		cs_n_next   = cs_n_reg;
		og_n_next   = og_n_reg;
		we_n_next   = we_n_reg;
		ready_next  = 1'b0;
		rvalid_next = 1'b0;
		wdone_next  = 1'b0;
		sel_on_next = 1'b0;
		drive_next  = 1'b0;
		load        = 1'b0;
		capture     = 1'b0;
		case (state_reg)
		S_IDLE: begin
			ready_next = 1'b1;
			if (req_i) begin
				// lane selects and data set up ahead of the window [R8]
				load        = 1'b1;
				ready_next  = 1'b0;
				sel_on_next = 1'b1;
				// bus is floating here, so driving is safe [R11]
				drive_next  = we_i;
				state_next  = S_SETUP;
			end
		end
		S_SETUP: begin
			// address has been stable for a cycle already [R12]
			sel_on_next = 1'b1;
			drive_next  = wr_reg;
			cs_n_next   = `ASRC_PIN_ON; // [R2]
			if (wr_reg) begin
				og_n_next  = `ASRC_PIN_OFF; // [R10]
				we_n_next  = `ASRC_PIN_ON; // [R7] [R8]
				cnt_next   = WP_LD;
				state_next = S_WR_PLS;
			end else begin
				og_n_next  = `ASRC_PIN_ON; // [R6]
				we_n_next  = `ASRC_PIN_OFF; // [R6]
				cnt_next   = ACC_LD;
				state_next = S_RD_ACC;
			end
		end
		S_RD_ACC: begin
			sel_on_next = 1'b1;
			if (cnt_reg == {CW{1'b0}}) begin
				capture     = 1'b1;
				cs_n_next   = `ASRC_PIN_OFF;
				og_n_next   = `ASRC_PIN_OFF; // [R3]
				sel_on_next = 1'b0;
				rvalid_next = 1'b1;
				state_next  = S_RD_END;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		S_RD_END: begin
			// wait for the memory to release the bus [R11]
			cnt_next   = HZ_LD;
			state_next = S_TURN;
		end
		S_TURN: begin
			if (cnt_reg == {CW{1'b0}}) begin
				ready_next = 1'b1;
				state_next = S_IDLE;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		S_WR_PLS: begin
			sel_on_next = 1'b1;
			drive_next  = 1'b1;
			if (cnt_reg == {CW{1'b0}}) begin
				// both end the write at once; data still held [R9]
				cs_n_next  = `ASRC_PIN_OFF;
				we_n_next  = `ASRC_PIN_OFF;
				wdone_next = 1'b1;
				state_next = S_WR_END;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		S_WR_END: begin
			// data released one cycle after the ending edge [R9]
			ready_next = 1'b1;
			state_next = S_IDLE;
		end
		default: begin
			cs_n_next  = `ASRC_PIN_OFF;
			og_n_next  = `ASRC_PIN_OFF;
			we_n_next  = `ASRC_PIN_OFF;
			state_next = S_IDLE;
		end
		endcase
	end

	// =================================================================
	// registers
	// =================================================================
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg  <= S_IDLE;
			cnt_reg    <= {CW{1'b0}};
			wr_reg     <= 1'b0;
			addr_reg   <= {AW{1'b0}};
			cs_n_reg   <= `ASRC_PIN_OFF;
			og_n_reg   <= `ASRC_PIN_OFF;
			we_n_reg   <= `ASRC_PIN_OFF;
			ready_reg  <= 1'b0;
			rvalid_reg <= 1'b0;
			wdone_reg  <= 1'b0;
		end else if (ce_i) begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			cs_n_reg   <= cs_n_next;
			og_n_reg   <= og_n_next;
			we_n_reg   <= we_n_next;
			ready_reg  <= ready_next;
			rvalid_reg <= rvalid_next;
			wdone_reg  <= wdone_next;
			if (load) begin
				wr_reg   <= we_i;
				addr_reg <= addr_i; // [R1]
			end
		end
	end

	// =================================================================
	// byte lanes: [1] upper pins, [0] lower pins
	// =================================================================
	asrc_lane #(.W(HW)) u_upper (
		.clock_i   (clock_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.load_i    (load),
		.en_i      (be_i[1]),
		.wdata_i   (wdata_i[DW-1:HW]),
		.sel_on_i  (sel_on_next),
		.drive_i   (drive_next),
		.capture_i (capture),
		.pin_i     (data_pins_i[DW-1:HW]),
		.sel_n_o   (upper_lane_sel_n_o), // [R5]
		.pin_o     (data_pins_o[DW-1:HW]),
		.pin_oe_o  (data_pins_oe_o[DW-1:HW]),
		.rdata_o   (rdata_o[DW-1:HW])
	);

	asrc_lane #(.W(HW)) u_lower (
		.clock_i   (clock_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.load_i    (load),
		.en_i      (be_i[0]),
		.wdata_i   (wdata_i[HW-1:0]),
		.sel_on_i  (sel_on_next),
		.drive_i   (drive_next),
		.capture_i (capture),
		.pin_i     (data_pins_i[HW-1:0]),
		.sel_n_o   (lower_lane_sel_n_o), // [R5]
		.pin_o     (data_pins_o[HW-1:0]),
		.pin_oe_o  (data_pins_oe_o[HW-1:0]),
		.rdata_o   (rdata_o[HW-1:0])
	);

	assign ready_o          = ready_reg;
	assign rvalid_o         = rvalid_reg;
	assign wdone_o          = wdone_reg;
	assign word_addr_o      = addr_reg;
	assign chip_sel_n_o     = cs_n_reg;
	assign out_gate_n_o     = og_n_reg;
	assign write_strobe_n_o = we_n_reg;

endmodule // asrc_ctrl

// *** src/asrc_lane.v ***
`timescale 1ns/1ps
`include "asrc_regs.vh"

// =====================================================================
// one byte lane: lane select, write drive and read capture
// =====================================================================
module asrc_lane #(
	parameter W = `ASRC_LANE_W
) (
	input  wire         clock_i,
	input  wire         arst_n_i,
	input  wire         ce_i,
	input  wire         load_i,
	input  wire         en_i,
	input  wire [W-1:0] wdata_i,
	input  wire         sel_on_i,
	input  wire         drive_i,
	input  wire         capture_i,
	input  wire [W-1:0] pin_i,
	output wire         sel_n_o,
	output wire [W-1:0] pin_o,
	output wire [W-1:0] pin_oe_o,
	output wire [W-1:0] rdata_o
);

	reg         en_reg;
	reg         sel_n_reg;
	reg [W-1:0] dout_reg;
	reg [W-1:0] oe_reg;
	reg [W-1:0] rdata_reg;

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_reg    <= 1'b0;
			sel_n_reg <= `ASRC_PIN_OFF;
			dout_reg  <= {W{1'b0}};
			oe_reg    <= {W{1'b0}};
			rdata_reg <= {W{1'b0}};
		end else if (ce_i) begin
			if (load_i) begin
				en_reg   <= en_i;
				dout_reg <= wdata_i;
			end
			// a lane not enabled keeps its select high [R4] [R5]
			sel_n_reg <= ~(sel_on_i & (load_i ? en_i : en_reg));
			oe_reg    <= {W{drive_i & (load_i ? en_i : en_reg)}};
			// a disabled lane keeps its last byte; its pins float [R4]
			if (capture_i & en_reg)
				rdata_reg <= pin_i;
		end
	end

	assign sel_n_o  = sel_n_reg;
	assign pin_o    = dout_reg;
	assign pin_oe_o = oe_reg;
	assign rdata_o  = rdata_reg;

endmodule // asrc_lane

// *** src/asrc_regs.vh ***
`ifndef ASRC_REGS_VH
`define ASRC_REGS_VH

// =====================================================================
// clock and memory timing, nanoseconds
// =====================================================================
`define ASRC_CLK_PERIOD_NS 50
// longest address / select access time of the slowest grade
`define ASRC_T_ACCESS_NS   15
// least write pulse width of the slowest grade
`define ASRC_T_WP_NS       10
// longest time for the memory to float its pins after deselect
`define ASRC_T_HZ_NS       7

// least times round up to whole cycles, never below one
`define ASRC_CYC_MIN(t) \
	((((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : \
	(((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS))

`define ASRC_ACC_CYC `ASRC_CYC_MIN(`ASRC_T_ACCESS_NS)
`define ASRC_WP_CYC  `ASRC_CYC_MIN(`ASRC_T_WP_NS)
`define ASRC_HZ_CYC  `ASRC_CYC_MIN(`ASRC_T_HZ_NS)

// =====================================================================
// pin levels and widths
// =====================================================================
`define ASRC_PIN_OFF     1'b1
`define ASRC_PIN_ON      1'b0
`define ASRC_ADDR_W      16
`define ASRC_DATA_W      16
`define ASRC_LANE_W      8
`define ASRC_CNT_W       4

`endif

// *** tb/asrc_ctrl_assertions.sv ***
`timescale 1ns/1ps
// =====================================================================
// pin protocol checks on the memory controller
// =====================================================================
module asrc_ctrl_assertions (
	input wire        clock_i,
	input wire        arst_n_i,
	input wire        ce_i,
	input wire        req_i,
	input wire        ready_o,
	input wire        rvalid_o,
	input wire        wdone_o,
	input wire [15:0] word_addr_o,
	input wire        chip_sel_n_o,
	input wire        out_gate_n_o,
	input wire        write_strobe_n_o,
	input wire [15:0] data_pins_o,
	input wire [15:0] data_pins_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_gate_high_write: assert property (
		!write_strobe_n_o |-> out_gate_n_o) else $error("gate low in write");
	a_no_contention: assert property (
		!out_gate_n_o |-> data_pins_oe_o == 16'h0000)
		else $error("host drives during read");
	a_addr_before_sel: assert property (
		!chip_sel_n_o |-> $stable(word_addr_o)) else $error("address moved");
	a_data_held_end: assert property (
		$rose(write_strobe_n_o) |-> $stable(data_pins_o)
		&& data_pins_oe_o == $past(data_pins_oe_o)) else $error("data not held");
	a_strobe_in_sel: assert property (
		!write_strobe_n_o |-> !chip_sel_n_o) else $error("strobe outside select");
	a_write_window: assert property (
		wdone_o |-> $past(!write_strobe_n_o && !chip_sel_n_o) && write_strobe_n_o)
		else $error("write done without window");
	a_read_gated: assert property (
		rvalid_o |-> $past(!out_gate_n_o && write_strobe_n_o && !chip_sel_n_o))
		else $error("read without gate");
	a_take_latency: assert property (
		ready_o && req_i && ce_i |=> !ready_o ##1 !chip_sel_n_o
		##1 (rvalid_o || wdone_o)) else $error("transfer timing");
endmodule // asrc_ctrl_assertions

// *** tb/asrc_mem_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// behavioural 64k x 16 static memory, no clock
// =====================================================================
module asrc_mem_model (
	input  wire [15:0] word_addr_i,
	input  wire        chip_sel_n_i,
	input  wire        out_gate_n_i,
	input  wire        write_strobe_n_i,
	input  wire        upper_lane_sel_n_i,
	input  wire        lower_lane_sel_n_i,
	input  wire [15:0] data_pins_i,
	output wire [15:0] data_pins_o,
	output wire [15:0] data_pins_oe_o
);
	logic [15:0] mem [0:65535];
	wire rd = !chip_sel_n_i && !out_gate_n_i && write_strobe_n_i;
	assign data_pins_oe_o = rd ? {{8{!upper_lane_sel_n_i}},
		{8{!lower_lane_sel_n_i}}} : 16'h0000;
	assign data_pins_o = mem[word_addr_i];
	// data lands when the select and strobe overlap closes
	always @(posedge (chip_sel_n_i | write_strobe_n_i)) begin
		if (!upper_lane_sel_n_i)
			mem[word_addr_i][15:8] = data_pins_i[15:8];
		if (!lower_lane_sel_n_i)
			mem[word_addr_i][7:0] = data_pins_i[7:0];
	end
endmodule // asrc_mem_model

// *** tb/test_asrc_ctrl.sv ***
`timescale 1ns/1ps
// =====================================================================
// controller against the memory model
// =====================================================================
module test_asrc_ctrl;
	logic        clock_i, arst_n_i, ce_i, req_i, we_i;
	logic [15:0] addr_i, wdata_i, junk;
	logic [1:0]  be_i;
	wire         ready_o, rvalid_o, wdone_o, chip_sel_n_o, out_gate_n_o;
	wire         write_strobe_n_o, upper_lane_sel_n_o, lower_lane_sel_n_o;
	wire  [15:0] rdata_o, word_addr_o, data_pins_o, data_pins_oe_o;
	wire  [15:0] m_d, m_oe, bus;
	int          n_errors = 0, comparisons = 0, cycles = 0;
	// undriven pins show a pattern that flips every cycle
	assign bus = (data_pins_o & data_pins_oe_o) | (m_d & m_oe)
		| (junk & ~data_pins_oe_o & ~m_oe);
	asrc_ctrl i_asrc_ctrl (.clock_i, .arst_n_i, .ce_i, .req_i, .we_i,
		.addr_i, .wdata_i, .be_i, .ready_o, .rvalid_o, .rdata_o, .wdone_o,
		.word_addr_o, .chip_sel_n_o, .out_gate_n_o, .write_strobe_n_o,
		.upper_lane_sel_n_o, .lower_lane_sel_n_o, .data_pins_i(bus),
		.data_pins_o, .data_pins_oe_o);
	asrc_mem_model i_asrc_mem_model (.word_addr_i(word_addr_o),
		.chip_sel_n_i(chip_sel_n_o), .out_gate_n_i(out_gate_n_o),
		.write_strobe_n_i(write_strobe_n_o), .data_pins_i(bus),
		.upper_lane_sel_n_i(upper_lane_sel_n_o),
		.lower_lane_sel_n_i(lower_lane_sel_n_o),
		.data_pins_o(m_d), .data_pins_oe_o(m_oe));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		junk <= ~junk;
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			n_errors++;
			end_of_test;
		end
	end
	task check(input string what, input [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task op(input w, input [15:0] a, d, input [1:0] b);
		int n;
		n = 0;
		while (ready_o !== 1'b1 && n < 20) begin
			@(negedge clock_i);
			n++;
		end
		if (n >= 20)
			n_errors++;
		@(posedge clock_i);
		req_i <= 1'b1;
		we_i <= w;
		addr_i <= a;
		wdata_i <= d;
		be_i <= b;
		@(posedge clock_i);
		req_i <= 1'b0;
		do begin
			@(negedge clock_i);
			n++;
		end while (!(rvalid_o === 1'b1 || wdone_o === 1'b1) && n < 40);
		if (n >= 40)
			n_errors++;
	endtask
	task rd(input [15:0] a, input [1:0] b, input [15:0] e);
		op(1'b0, a, 16'h0000, b);
		check("rdata", rdata_o, e);
	endtask
	task s_full;
		op(1'b1, 16'hffff, 16'h1234, 2'b11);
		op(1'b1, 16'h0000, 16'ha5c3, 2'b11);
		rd(16'hffff, 2'b11, 16'h1234);
		rd(16'h0000, 2'b11, 16'ha5c3);
	endtask
	task s_lanes;
		op(1'b1, 16'h0000, 16'h7e11, 2'b10);
		rd(16'h0000, 2'b11, 16'h7ec3);
		op(1'b1, 16'h0000, 16'h2299, 2'b01);
		op(1'b1, 16'h0000, 16'hffff, 2'b00);
		rd(16'hffff, 2'b01, 16'h7e34);
		rd(16'hffff, 2'b10, 16'h1234);
		rd(16'h0000, 2'b11, 16'h7e99);
	endtask
	// clock enable low: a pending request is not taken until it rises
	task s_freeze;
		while (ready_o !== 1'b1)
			@(negedge clock_i);
		@(posedge clock_i);
		ce_i <= 1'b0;
		req_i <= 1'b1;
		we_i <= 1'b0;
		addr_i <= 16'hffff;
		be_i <= 2'b11;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		check("frozen select", {15'h0000, chip_sel_n_o}, 16'h0001);
		check("frozen ready", {15'h0000, ready_o}, 16'h0001);
		@(posedge clock_i);
		ce_i <= 1'b1;
		@(posedge clock_i);
		req_i <= 1'b0;
		repeat (3) @(negedge clock_i);
		check("thawed valid", {15'h0000, rvalid_o}, 16'h0001);
		check("thawed rdata", rdata_o, 16'h1234);
	endtask
	task s_idle;
		@(negedge clock_i);
		check("select", {15'h0000, chip_sel_n_o}, 16'h0001);
		check("mem drive", m_oe, 16'h0000);
		check("host drive", data_pins_oe_o, 16'h0000);
		check("lanes", {14'h0000, upper_lane_sel_n_o, lower_lane_sel_n_o},
			16'h0003);
	endtask
	task end_of_test;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		arst_n_i = 1'b0;
		ce_i = 1'b1;
		req_i = 1'b0;
		we_i = 1'b0;
		addr_i = 16'h0000;
		wdata_i = 16'h0000;
		be_i = 2'b00;
		junk = 16'h5a5a;
		repeat (3) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(negedge clock_i);
		s_full;
		s_lanes;
		s_freeze;
		s_idle;
		end_of_test;
	end
endmodule // test_asrc_ctrl

bind asrc_ctrl asrc_ctrl_assertions i_asrc_ctrl_assertions (.clock_i,
	.arst_n_i, .ce_i, .req_i, .ready_o, .rvalid_o, .wdone_o, .word_addr_o,
	.chip_sel_n_o, .out_gate_n_o, .write_strobe_n_o, .data_pins_o,
	.data_pins_oe_o);
